// [dpfc_pkg.sv]
// Package: register map, field layout, reset values, ranges and timing of the dual controller feedback combiner
package dpfc_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;
	localparam int REG_W = 32;
	// Full scale 100.00 % in hundredths of a percent
	localparam logic signed [15:0] FULL_SCALE = 16'sh2710;
	localparam logic [13:0] BOOST_LEVEL_MAX = 14'h2710;
	localparam logic [11:0] BOOST_TIME_MAX = 12'h9C4;
	localparam logic [12:0] SCALE_MAX = 13'hFA0;
	localparam logic signed [31:0] SCALE_ONE = 32'sh000003E8;
	// Register byte addresses
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] SCALE_ADDR = 8'h04;
	localparam logic [7:0] BOOST_LEVEL_ADDR = 8'h08;
	localparam logic [7:0] BOOST_TIME_ADDR = 8'h0C;
	localparam logic [7:0] SLEEP_THR_ADDR = 8'h10;
	localparam logic [7:0] STATUS_ADDR = 8'h14;
	localparam logic [7:0] FINAL_FB_ADDR = 8'h18;
	// Control register fields
	localparam int CTRL_EN2_LSB = 0;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_SQRT1_BIT = 5;
	localparam int CTRL_SQRT2_BIT = 6;
	localparam int CTRL_SQRTC_BIT = 7;
	localparam int CTRL_SLEEP_EN_BIT = 8;
	localparam int CTRL_MOTOR_BIT = 9;
	// Status register fields
	localparam int STAT_BOOST_EN_BIT = 0;
	localparam int STAT_BOOSTING_BIT = 1;
	localparam int STAT_STOP_BIT = 2;
	localparam int STAT_RUN2_BIT = 3;
	// Reset values
	localparam logic [1:0] EN2_RESET = 2'h0;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [12:0] SCALE_RESET = 13'h0000;
	localparam logic [13:0] BOOST_LEVEL_RESET = 14'h0000;
	localparam logic [11:0] BOOST_TIME_RESET = 12'h000;
	localparam logic signed [15:0] SLEEP_THR_RESET = 16'sh0000;
	// Second controller enable settings
	localparam logic [1:0] EN2_OFF = 2'h0;
	localparam logic [1:0] EN2_ON = 2'h1;
	localparam logic [1:0] EN2_FOLLOW = 2'h2;
	// Feedback mode settings
	localparam logic [2:0] MODE_FB1 = 3'h0;
	localparam logic [2:0] MODE_FB2 = 3'h1;
	localparam logic [2:0] MODE_SUM = 3'h2;
	localparam logic [2:0] MODE_MIN = 3'h3;
	localparam logic [2:0] MODE_MAX = 3'h4;
	localparam logic [2:0] MODE_MEAN = 3'h5;
	localparam logic [2:0] MODE_ERR_MIN = 3'h6;
	localparam logic [2:0] MODE_ERR_MAX = 3'h7;
	// Boost duration is counted in 0.1 s steps
	localparam int CLK_PERIOD_NS = 20;
	localparam int BOOST_STEP_NS = 100000000;
	localparam int BOOST_STEP_CYCLES = BOOST_STEP_NS / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		SLP_AWAKE,
		SLP_BOOST,
		SLP_ASLEEP
	} dpfc_sleep_state_type;
endpackage

// [dpfc_sqrt.sv]
// Signed square-root conditioning stage with registered output
`timescale 1ns/1ps
`default_nettype none
module dpfc_sqrt (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic signed [dpfc_pkg::DATA_W-1:0] din,
	output logic signed [dpfc_pkg::DATA_W-1:0] dout
);
	import dpfc_pkg::*;

	function automatic logic [13:0] isqrt(input logic [27:0] v);
		logic [27:0] rem;
		logic [27:0] root;
		logic [27:0] bit_q;
		rem = v;
		root = 28'h0;
		bit_q = 28'h4000000;
		for (int i = 0; i < 14; i++) begin
			if (rem >= (root | bit_q)) begin
				rem = rem - (root | bit_q);
				root = (root >> 1) | bit_q;
			end else begin
				root = root >> 1;
			end
			bit_q = bit_q >> 2;
		end
		return root[13:0];
	endfunction

	logic [15:0] mag;
	logic [27:0] prod;
	logic signed [15:0] res;

	always_comb begin
		if (din[15]) begin
			mag = 16'(-din);
		end else begin
			mag = din;
		end
		if (mag > 16'(FULL_SCALE)) begin
			mag = 16'(FULL_SCALE);
		end
		prod = 28'(mag) * 28'(FULL_SCALE);
		if (din[15]) begin
			res = -$signed({2'h0, isqrt(prod)});
		end else begin
			res = $signed({2'h0, isqrt(prod)});
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dout <= 16'sh0000;
		end else if (enable) begin
			dout <= res;
		end else begin
			dout <= din;
		end
	end
endmodule
`default_nettype wire

// [dpfc_combiner.sv]
// Feedback and error combiner for two cooperating process controllers, with pre-sleep boost
`timescale 1ns/1ps
`default_nettype none
module dpfc_combiner #(
	parameter int STEP_CYCLES = dpfc_pkg::BOOST_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [dpfc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dpfc_pkg::REG_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [dpfc_pkg::REG_W-1:0] reg_rdata,
	input wire logic signed [dpfc_pkg::DATA_W-1:0] fb1_in,
	input wire logic signed [dpfc_pkg::DATA_W-1:0] fb2_in,
	input wire logic signed [dpfc_pkg::DATA_W-1:0] ref1_in,
	input wire logic signed [dpfc_pkg::DATA_W-1:0] ref2_in,
	input wire logic first_controller_enable,
	input wire logic signed [dpfc_pkg::DATA_W-1:0] controller_output,
	output logic signed [dpfc_pkg::DATA_W-1:0] first_controller_feedback,
	output logic signed [dpfc_pkg::DATA_W-1:0] second_controller_feedback,
	output logic signed [dpfc_pkg::DATA_W-1:0] first_controller_reference,
	output logic signed [dpfc_pkg::DATA_W-1:0] first_controller_error,
	output logic signed [dpfc_pkg::DATA_W-1:0] second_controller_error,
	output logic second_controller_run,
	output logic second_controller_clear,
	output logic motor_stop,
	output logic boost_active
);
	import dpfc_pkg::*;

	localparam int TICK_W = $clog2(STEP_CYCLES + 1);

	function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'(FULL_SCALE)) begin
			return FULL_SCALE;
		end else if (v < -32'(FULL_SCALE)) begin
			return -FULL_SCALE;
		end else begin
			return v[15:0];
		end
	endfunction

	function automatic logic signed [31:0] wide(input logic signed [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	function automatic logic [15:0] absval(input logic signed [15:0] v);
		if (v[15]) begin
			return 16'(-v);
		end else begin
			return v;
		end
	endfunction

	// Software settings
	logic [1:0] en2_q;
	logic [2:0] mode_q;
	logic sqrt1_en_q;
	logic sqrt2_en_q;
	logic sqrtc_en_q;
	logic sleep_en_q;
	logic motor_ctl_q;
	logic [12:0] scale_q;
	logic [13:0] boost_level_q;
	logic [11:0] boost_time_q;
	logic signed [15:0] sleep_thr_q;

	// Datapath
	logic signed [15:0] sq1;
	logic signed [15:0] sq2;
	logic signed [15:0] comb_q;
	logic signed [15:0] fb2_b_q;
	logic signed [15:0] sqc;
	logic signed [15:0] fb2_c_q;
	logic signed [15:0] fb1_own_q;
	logic signed [15:0] fb1_own_c_q;
	logic signed [15:0] comb_d;
	logic signed [15:0] ref1_d;
	logic signed [15:0] err1_d;
	logic signed [15:0] err2_d;
	logic signed [31:0] scaled;
	logic signed [15:0] fb1_for_err;

	// Sleep and boost
	dpfc_sleep_state_type state_q;
	logic [TICK_W-1:0] tick_q;
	logic [11:0] remain_q;
	logic boost_enabled;
	logic sleep_cond;
	logic step_done;

	assign boost_enabled = (boost_level_q != 14'h0000) && (boost_time_q != 12'h000);
	assign sleep_cond = motor_ctl_q && sleep_en_q && (controller_output < sleep_thr_q);
	assign step_done = (tick_q == TICK_W'(STEP_CYCLES - 1));

	// Register writes; out-of-range values in bits 15:0 are clamped to the documented maximum, the sleep threshold to plus or minus full scale
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en2_q <= EN2_RESET;
			mode_q <= MODE_RESET;
			sqrt1_en_q <= 1'b0;
			sqrt2_en_q <= 1'b0;
			sqrtc_en_q <= 1'b0;
			sleep_en_q <= 1'b0;
			motor_ctl_q <= 1'b0;
			scale_q <= SCALE_RESET;
			boost_level_q <= BOOST_LEVEL_RESET;
			boost_time_q <= BOOST_TIME_RESET;
			sleep_thr_q <= SLEEP_THR_RESET;
		end else if (reg_wr) begin
			if (reg_addr == CTRL_ADDR) begin
				if (reg_wdata[CTRL_EN2_LSB +: 2] > EN2_FOLLOW) begin
					en2_q <= EN2_FOLLOW;
				end else begin
					en2_q <= reg_wdata[CTRL_EN2_LSB +: 2];
				end
				mode_q <= reg_wdata[CTRL_MODE_LSB +: 3];
				sqrt1_en_q <= reg_wdata[CTRL_SQRT1_BIT];
				sqrt2_en_q <= reg_wdata[CTRL_SQRT2_BIT];
				sqrtc_en_q <= reg_wdata[CTRL_SQRTC_BIT];
				sleep_en_q <= reg_wdata[CTRL_SLEEP_EN_BIT];
				motor_ctl_q <= reg_wdata[CTRL_MOTOR_BIT];
			end else if (reg_addr == SCALE_ADDR) begin
				if (reg_wdata[15:0] > 16'(SCALE_MAX)) begin
					scale_q <= SCALE_MAX;
				end else begin
					scale_q <= reg_wdata[12:0];
				end
			end else if (reg_addr == BOOST_LEVEL_ADDR) begin
				if (reg_wdata[15:0] > 16'(BOOST_LEVEL_MAX)) begin
					boost_level_q <= BOOST_LEVEL_MAX;
				end else begin
					boost_level_q <= reg_wdata[13:0];
				end
			end else if (reg_addr == BOOST_TIME_ADDR) begin
				if (reg_wdata[15:0] > 16'(BOOST_TIME_MAX)) begin
					boost_time_q <= BOOST_TIME_MAX;
				end else begin
					boost_time_q <= reg_wdata[11:0];
				end
			end else if (reg_addr == SLEEP_THR_ADDR) begin
				sleep_thr_q <= sat16(wide(reg_wdata[15:0]));
			end
		end
	end

	// Register reads, data in the following cycle; unmapped addresses read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			if (reg_addr == CTRL_ADDR) begin
				reg_rdata <= {22'h000000, motor_ctl_q, sleep_en_q, sqrtc_en_q, sqrt2_en_q, sqrt1_en_q, mode_q, en2_q};
			end else if (reg_addr == SCALE_ADDR) begin
				reg_rdata <= {19'h00000, scale_q};
			end else if (reg_addr == BOOST_LEVEL_ADDR) begin
				reg_rdata <= {18'h00000, boost_level_q};
			end else if (reg_addr == BOOST_TIME_ADDR) begin
				reg_rdata <= {20'h00000, boost_time_q};
			end else if (reg_addr == SLEEP_THR_ADDR) begin
				reg_rdata <= {16'h0000, sleep_thr_q};
			end else if (reg_addr == STATUS_ADDR) begin
				reg_rdata <= {28'h0000000, second_controller_run, motor_stop, boost_active, boost_enabled};
			end else if (reg_addr == FINAL_FB_ADDR) begin
				reg_rdata <= {16'h0000, first_controller_feedback};
			end else begin
				reg_rdata <= 32'h00000000;
			end
		end
	end

	// Second controller enable decode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			second_controller_run <= 1'b0;
			second_controller_clear <= 1'b1;
		end else begin
			second_controller_run <= (en2_q == EN2_ON) || ((en2_q == EN2_FOLLOW) && first_controller_enable);
			second_controller_clear <= (en2_q == EN2_OFF) || ((en2_q == EN2_FOLLOW) && !first_controller_enable);
		end
	end

	// Per-path square-root conditioning
	dpfc_sqrt u_sqrt1 (
		.clk(clk),
		.rst_n(rst_n),
		.enable(sqrt1_en_q),
		.din(fb1_in),
		.dout(sq1)
	);

	dpfc_sqrt u_sqrt2 (
		.clk(clk),
		.rst_n(rst_n),
		.enable(sqrt2_en_q),
		.din(fb2_in),
		.dout(sq2)
	);

	// Feedback selection or combination for the first controller
	always_comb begin
		case (mode_q)
			MODE_FB1: comb_d = sq1;
			MODE_FB2: comb_d = sq2;
			MODE_SUM: comb_d = sat16(wide(sq1) + wide(sq2));
			MODE_MIN: comb_d = (sq1 < sq2) ? sq1 : sq2;
			MODE_MAX: comb_d = (sq1 > sq2) ? sq1 : sq2;
			MODE_MEAN: comb_d = sat16((wide(sq1) + wide(sq2)) >>> 1);
			default: comb_d = sq1;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			comb_q <= 16'sh0000;
			fb2_b_q <= 16'sh0000;
			fb1_own_q <= 16'sh0000;
		end else begin
			comb_q <= comb_d;
			fb2_b_q <= sq2;
			fb1_own_q <= sq1;
		end
	end

	// Combined square root, then scaling
	dpfc_sqrt u_sqrtc (
		.clk(clk),
		.rst_n(rst_n),
		.enable(sqrtc_en_q),
		.din(comb_q),
		.dout(sqc)
	);

	// Factor made signed so that negative feedback keeps its sign through the product
	assign scaled = (wide(sqc) * $signed({19'h00000, scale_q})) / SCALE_ONE;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fb2_c_q <= 16'sh0000;
			fb1_own_c_q <= 16'sh0000;
			first_controller_feedback <= 16'sh0000;
			second_controller_feedback <= 16'sh0000;
		end else begin
			fb2_c_q <= fb2_b_q;
			fb1_own_c_q <= fb1_own_q;
			first_controller_feedback <= sat16(scaled);
			second_controller_feedback <= fb2_c_q;
		end
	end

	// Errors and dual-zone selection
	assign ref1_d = boost_active ? sat16(wide(ref1_in) + {18'h00000, boost_level_q}) : ref1_in;
	// Dual-zone modes take the first controller's own conditioned feedback, unscaled
	assign fb1_for_err = (mode_q >= MODE_ERR_MIN) ? fb1_own_c_q : first_controller_feedback;
	assign err1_d = sat16(wide(ref1_d) - wide(fb1_for_err));
	assign err2_d = sat16(wide(ref2_in) - wide(second_controller_feedback));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			first_controller_reference <= 16'sh0000;
			first_controller_error <= 16'sh0000;
			second_controller_error <= 16'sh0000;
		end else begin
			first_controller_reference <= ref1_d;
			second_controller_error <= err2_d;
			if (mode_q == MODE_ERR_MIN) begin
				first_controller_error <= (absval(err2_d) < absval(err1_d)) ? err2_d : err1_d;
			end else if (mode_q == MODE_ERR_MAX) begin
				first_controller_error <= (absval(err2_d) > absval(err1_d)) ? err2_d : err1_d;
			end else begin
				first_controller_error <= err1_d;
			end
		end
	end

	// Sleep entry with optional pre-sleep boost
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SLP_AWAKE;
		end else begin
			case (state_q)
				SLP_AWAKE: begin
					if (sleep_cond && boost_enabled) begin
						state_q <= SLP_BOOST;
					end else if (sleep_cond) begin
						state_q <= SLP_ASLEEP;
					end
				end
				SLP_BOOST: begin
					if (step_done && (remain_q == 12'h001)) begin
						state_q <= sleep_cond ? SLP_ASLEEP : SLP_AWAKE;
					end
				end
				SLP_ASLEEP: begin
					if (!sleep_cond) begin
						state_q <= SLP_AWAKE;
					end
				end
				default: state_q <= SLP_AWAKE;
			endcase
		end
	end

	// Boost duration in 0.1 s steps
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= '0;
			remain_q <= 12'h000;
		end else if (state_q != SLP_BOOST) begin
			tick_q <= '0;
			remain_q <= boost_time_q;
		end else if (step_done) begin
			tick_q <= '0;
			remain_q <= remain_q - 12'h001;
		end else begin
			tick_q <= tick_q + TICK_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			motor_stop <= 1'b0;
			boost_active <= 1'b0;
		end else begin
			motor_stop <= (state_q == SLP_ASLEEP);
			boost_active <= (state_q == SLP_BOOST);
		end
	end
endmodule
`default_nettype wire

// [dpfc_assertions.sv]
// Checker watching the ports of the dual controller feedback combiner
`timescale 1ns/1ps
`default_nettype none
module dpfc_checker #(
	parameter int STEP_CYCLES = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [dpfc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dpfc_pkg::REG_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [dpfc_pkg::REG_W-1:0] reg_rdata,
	input wire logic first_controller_enable,
	input wire logic signed [dpfc_pkg::DATA_W-1:0] ref2_in,
	input wire logic signed [dpfc_pkg::DATA_W-1:0] first_controller_feedback,
	input wire logic signed [dpfc_pkg::DATA_W-1:0] second_controller_feedback,
	input wire logic signed [dpfc_pkg::DATA_W-1:0] second_controller_error,
	input wire logic second_controller_run,
	input wire logic second_controller_clear,
	input wire logic motor_stop,
	input wire logic boost_active
);
	import dpfc_pkg::*;
	logic [1:0] en2_q;
	logic [1:0] slp_q;
	logic lvl_q;
	logic [11:0] bt_q;
	int len_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Shadow of the control settings written by software
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en2_q <= EN2_RESET;
			slp_q <= 2'h0;
		end else if (reg_wr && reg_addr == CTRL_ADDR) begin
			en2_q <= (reg_wdata[1:0] == 2'h3) ? EN2_FOLLOW : reg_wdata[1:0];
			slp_q <= reg_wdata[9:8];
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lvl_q <= 1'b0;
			bt_q <= BOOST_TIME_RESET;
		end else if (reg_wr) begin
			// Over-range writes clamp to the maximum
			if (reg_addr == BOOST_LEVEL_ADDR) lvl_q <= (reg_wdata[15:0] != 16'h0000);
			if (reg_addr == BOOST_TIME_ADDR) bt_q <= (reg_wdata[15:0] > 16'(BOOST_TIME_MAX)) ? BOOST_TIME_MAX : reg_wdata[11:0];
		end
	end
	// Length of the current boost in cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			len_q <= 0;
		else
			len_q <= boost_active ? len_q + 1 : 0;
	end
	chk_clear_off: assert property (
		$stable(en2_q) && en2_q == EN2_OFF |-> second_controller_clear && !second_controller_run)
		else $error("second controller not cleared while off");
	chk_run_on: assert property (
		$stable(en2_q) && en2_q == EN2_ON |-> second_controller_run && !second_controller_clear)
		else $error("second controller not running while on");
	chk_run_follow: assert property (
		$stable(en2_q) && en2_q == EN2_FOLLOW && $stable(first_controller_enable)
		|-> second_controller_run == first_controller_enable)
		else $error("second controller does not follow the first");
	chk_err_own: assert property (
		$past(rst_n) |-> second_controller_error == 16'($past(ref2_in) - $past(second_controller_feedback)))
		else $error("second error not from its own feedback");
	chk_fb_sat: assert property (
		first_controller_feedback <= FULL_SCALE && first_controller_feedback >= -FULL_SCALE)
		else $error("final feedback beyond full scale");
	chk_boost_len: assert property (
		$fell(boost_active) |-> len_q == bt_q * STEP_CYCLES)
		else $error("boost length wrong");
	chk_boost_cond: assert property (
		$rose(boost_active) |-> lvl_q && bt_q != 12'h0 && slp_q == 2'h3)
		else $error("boost started without its settings");
	chk_flag_read: assert property (
		reg_rd && reg_addr == STATUS_ADDR |=> reg_rdata[STAT_BOOST_EN_BIT] == (lvl_q && bt_q != 12'h0))
		else $error("boost enabled flag wrong");
	chk_stop_excl: assert property (
		!(motor_stop && boost_active))
		else $error("motor stopped during boost");
	chk_stop_cond: assert property (
		$rose(motor_stop) |-> slp_q == 2'h3)
		else $error("motor stopped without sleep control");
endmodule
bind dpfc_combiner dpfc_checker #(.STEP_CYCLES(STEP_CYCLES)) u_dpfc_checker (
	.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .first_controller_enable, .ref2_in,
	.first_controller_feedback, .second_controller_feedback, .second_controller_error, .second_controller_run,
	.second_controller_clear, .motor_stop, .boost_active
);
`default_nettype wire

// [dpfc_combiner_bench.sv]
// Self-checking bench for the dual controller feedback combiner
`timescale 1ns/1ps
`default_nettype none
module dpfc_combiner_bench;
	import dpfc_pkg::*;
	localparam int STEP = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [REG_W-1:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [REG_W-1:0] reg_rdata;
	logic first_controller_enable = 1'b0;
	logic signed [DATA_W-1:0] fb1_in = 16'sh0, fb2_in = 16'sh0, ref1_in = 16'sh01F4, ref2_in = 16'sh07D0;
	logic signed [DATA_W-1:0] controller_output = 16'sh1388;
	logic signed [DATA_W-1:0] first_controller_feedback, second_controller_feedback, first_controller_reference;
	logic signed [DATA_W-1:0] first_controller_error, second_controller_error;
	logic second_controller_run, second_controller_clear, motor_stop, boost_active;
	int failures = 0;
	int total_checks = 0;
	int e1, e2, m, n;
	// Control word, scale, feedback 1, feedback 2, expected first and second feedback
	int t[19][6] = '{'{'h01, 1000, 3000, -1000, 3000, -1000}, '{'h05, 1000, 3000, -1000, -1000, -1000},
		'{'h09, 1000, 3000, -1000, 2000, -1000}, '{'h0D, 1000, 3000, -1000, -1000, -1000},
		'{'h11, 1000, 3000, -1000, 3000, -1000}, '{'h15, 1000, 3000, -1000, 1000, -1000},
		'{'h19, 1000, 3000, -1000, 3000, -1000}, '{'h1D, 1000, 3000, -1000, 3000, -1000},
		'{'h21, 1000, 2500, 900, 5000, 900}, '{'h21, 1000, -400, 900, -2000, 900},
		'{'h41, 1000, 2500, 900, 2500, 3000}, '{'h81, 1000, 100, 900, 1000, 900},
		'{'hA1, 1000, 100, 900, 3162, 900}, '{'h09, 1000, 9000, 8000, 10000, 8000},
		'{'h01, 2000, 3000, 900, 6000, 900}, '{'h01, 4000, 3000, 900, 10000, 900},
		'{'h01, 0, 3000, 900, 0, 900}, '{'h01, 500, -3001, 900, -1500, 900},
		'{'h19, 2000, 3000, -1000, 6000, -1000}};
	dpfc_combiner #(.STEP_CYCLES(STEP)) DUT (
		.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fb1_in, .fb2_in, .ref1_in, .ref2_in,
		.first_controller_enable, .controller_output, .first_controller_feedback, .second_controller_feedback,
		.first_controller_reference, .first_controller_error, .second_controller_error, .second_controller_run,
		.second_controller_clear, .motor_stop, .boost_active
	);
	always #10 clk = ~clk;
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, e, "register read");
	endtask
	task automatic settle;
		repeat (7) @(posedge clk);
		#1;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#400000;
		failures++;
		$display("mismatch at %0t: watchdog expired", $time);
		tally_and_finish();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 32; a += 4) expect_reg(8'(a), 32'h0);
		wr(SCALE_ADDR, 32'd5000);
		expect_reg(SCALE_ADDR, 32'hFA0);
		foreach (t[i]) begin
			wr(CTRL_ADDR, t[i][0]);
			wr(SCALE_ADDR, t[i][1]);
			@(posedge clk);
			fb1_in <= 16'(t[i][2]);
			fb2_in <= 16'(t[i][3]);
			settle();
			m = t[i][0] >> 2 & 7;
			// Dual-zone rows use the own unscaled first feedback; their first root is off
			e1 = 500 - (m >= 6 ? t[i][2] : t[i][4]);
			e2 = 2000 - t[i][5];
			if (m == 6 && e2 * e2 < e1 * e1 || m == 7 && e2 * e2 > e1 * e1) e1 = e2;
			check(first_controller_feedback, t[i][4], "final feedback");
			check(second_controller_feedback, t[i][5], "second feedback");
			check(first_controller_error, e1, "first error");
			check(second_controller_error, e2, "second error");
		end
		wr(CTRL_ADDR, 32'h0);
		settle();
		check({second_controller_clear, second_controller_run}, 2'b10, "disabled second");
		@(posedge clk);
		first_controller_enable <= 1'b1;
		wr(CTRL_ADDR, 32'h2);
		settle();
		check({second_controller_clear, second_controller_run}, 2'b01, "following enabled");
		@(posedge clk);
		first_controller_enable <= 1'b0;
		settle();
		check(second_controller_run, 1'b0, "following disabled");
		wr(CTRL_ADDR, 32'h301);
		wr(SLEEP_THR_ADDR, 32'd1000);
		wr(BOOST_LEVEL_ADDR, 32'd500);
		wr(BOOST_TIME_ADDR, 32'd2);
		wr(STATUS_ADDR, 32'hF);
		expect_reg(STATUS_ADDR, 32'h9);
		@(posedge clk);
		controller_output <= 16'sh0;
		n = 0;
		while (boost_active !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		n = 0;
		while (boost_active === 1'b1 && n < 40) begin
			if (n == 1) check(first_controller_reference, 1000, "boosted reference");
			@(posedge clk);
			#1;
			n++;
		end
		check(n, 2 * STEP, "boost length");
		repeat (2) @(posedge clk);
		#1;
		check(motor_stop, 1'b1, "asleep after boost");
		@(posedge clk);
		controller_output <= 16'sh1388;
		settle();
		check({motor_stop, boost_active}, 2'b00, "awake again");
		wr(BOOST_LEVEL_ADDR, 32'h0);
		expect_reg(STATUS_ADDR, 32'h8);
		@(posedge clk);
		controller_output <= 16'sh0;
		settle();
		check({motor_stop, boost_active}, 2'b10, "sleep without boost");
		wr(CTRL_ADDR, 32'h101);
		settle();
		check(motor_stop, 1'b0, "no stop without motor control");
		tally_and_finish();
	end
endmodule
`default_nettype wire
